// File: logic/dsz_bridge.sv
// AHB-Lite bridge from a 64-bit master bus to a 32-bit slave bus.
//
// Notes on behaviour
// - Bridge 64-bit master bus to 32-bit slave.
// - Unselected: pass size, downstream select low.
// - Unselected: ready mux follows upstream ready.
// - Narrow selected transfers pass through unchanged.
// - Address bit two picks write data word.
// - Narrow read data replicated on both halves.
// - Slave error response forwarded upstream.
// - Pending request captured, replayed next cycle.
// - Replay inserts one upstream wait state.
// - Block-all set: block remaining beats, error.
// - Block-all clear: block only 64-bit bursts.
// - Master id width and block-all default one.
// - Blocked beats: error upstream, idle downstream.
// - Blocking ends on nonsequential or deselect.
// - Busy during blocking gets okay response.
`timescale 1ns/1ps
`default_nettype none

module dsz_bridge #(
  parameter int MASTER_ID_WIDTH = 1,
  parameter bit BLOCK_ALL_SIZES = 1'b1
) (
  input  wire logic                          clock_i,
  input  wire logic                          rstn_i,
  input  wire logic                          upstream_select_i,
  input  wire dsz_pkg::dsz_ctrl_t            upstream_ctrl_i,
  input  wire logic [MASTER_ID_WIDTH-1:0]    upstream_master_i,
  input  wire logic [dsz_pkg::WIDE_W-1:0]    upstream_write_data_i,
  input  wire logic                          upstream_ready_in_i,
  output var  logic                          upstream_ready_o,
  output var  logic                          upstream_resp_o,
  output var  logic [dsz_pkg::WIDE_W-1:0]    upstream_read_data_o,
  output var  logic                          downstream_select_o,
  output var  dsz_pkg::dsz_ctrl_t            downstream_ctrl_o,
  output var  logic [MASTER_ID_WIDTH-1:0]    downstream_master_o,
  output var  logic [dsz_pkg::NARROW_W-1:0]  downstream_write_data_o,
  output var  logic                          downstream_ready_mux_o,
  input  wire logic [dsz_pkg::NARROW_W-1:0]  downstream_read_data_i,
  input  wire logic                          downstream_slave_ready_i,
  input  wire logic                          downstream_slave_response_i
);
  import dsz_pkg::*;

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  dsz_state_t                 state_r;
  dsz_state_t                 state_nxt;
  dsz_ctrl_t                  pend_r;
  logic [MASTER_ID_WIDTH-1:0] pend_master_r;
  logic                       data_own_r;
  logic                       data_sel_r;
  logic                       blocking_r;
  logic                       blocking_nxt;

  // ---------------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------------
  wire in_hold   = (state_r == ST_ERR1) || (state_r == ST_REPLAY);
  wire acc       = upstream_select_i && upstream_ready_in_i && !in_hold;
  wire is_seq    = (upstream_ctrl_i.trans == TRANS_SEQ);
  wire is_nseq   = (upstream_ctrl_i.trans == TRANS_NONSEQ);
  wire is_busy   = (upstream_ctrl_i.trans == TRANS_BUSY);
  wire is_valid  = upstream_ctrl_i.trans[1];
  wire is_wide   = (upstream_ctrl_i.size == SIZE_64);
  // Final cycle of a two-cycle error from the narrow slave.
  wire err_end   = data_own_r && downstream_slave_response_i
                   && downstream_slave_ready_i;
  wire blk_elig  = BLOCK_ALL_SIZES || is_wide;
  wire blk_armed = (blocking_r || err_end) && blk_elig;
  // Wide beats are not split here, so they are refused with an error;
  // this keeps a 64-bit burst blocked beat after beat.
  wire local_err  = acc && is_valid
                    && (is_wide || (is_seq && blk_armed));
  wire local_busy = acc && is_busy && blk_armed;
  wire replay     = err_end && acc && is_valid && !local_err;
  // The second error cycle has the ready mux high, so the downstream
  // bus would sample the next request; it sees IDLE instead.
  wire kill_ds    = err_end || local_err || local_busy
                    || (state_r == ST_ERR1);

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    state_nxt = ST_PASS;
    if (local_err) begin
      state_nxt = ST_ERR1;
    end else if (local_busy) begin
      state_nxt = ST_BLOCK;
    end else if (replay) begin
      state_nxt = ST_REPLAY;
    end else if (state_r == ST_ERR1) begin
      state_nxt = ST_ERR2;
    // Hold a local answer only while the bus stalls; after a deselect
    // the idle bridge must fall back to ready and OKAY.
    end else if ((state_r == ST_ERR2 || state_r == ST_BLOCK)
                 && !upstream_ready_in_i) begin
      state_nxt = state_r;
    end
  end

  // Setting wins over clearing so a continuation seen with a
  // nonsequential in the same cycle cannot happen; deselect ends it.
  always_comb begin
    blocking_nxt = blocking_r;
    if (!upstream_select_i || (acc && is_nseq)) begin
      blocking_nxt = 1'b0;
    end
    if ((local_err || local_busy) && !is_nseq && blk_elig) begin
      blocking_nxt = 1'b1;
    end
  end

  // ---------------------------------------------------------------------
  // Downstream address phase
  // ---------------------------------------------------------------------
  wire       replaying = (state_r == ST_REPLAY);
  dsz_ctrl_t pass_ctrl;
  always_comb begin
    pass_ctrl = upstream_ctrl_i;
    if (kill_ds) begin
      pass_ctrl.trans = TRANS_IDLE;
    end
  end

  assign downstream_ctrl_o      = replaying ? pend_r : pass_ctrl;
  assign downstream_master_o    = replaying ? pend_master_r
                                            : upstream_master_i;
  assign downstream_select_o    = replaying || upstream_select_i;
  // During replay the upstream bus is stalled but the idle downstream
  // bus must still take the captured request.
  assign downstream_ready_mux_o = replaying || upstream_ready_in_i;

  // ---------------------------------------------------------------------
  // Data phase routing
  // ---------------------------------------------------------------------
  assign downstream_write_data_o = data_sel_r
      ? upstream_write_data_i[WIDE_W-1:NARROW_W]
      : upstream_write_data_i[NARROW_W-1:0];
  assign upstream_read_data_o = {downstream_read_data_i,
                                 downstream_read_data_i};

  // With no downstream data phase in progress the bridge itself answers ready and okay.
  wire pass_ready = data_own_r ? downstream_slave_ready_i : 1'b1;
  wire pass_resp  = data_own_r ? downstream_slave_response_i
                               : RESP_OKAY;

  always_comb begin
    upstream_ready_o = pass_ready;
    upstream_resp_o  = pass_resp;
    unique case (state_r)
      ST_PASS: begin
        upstream_ready_o = pass_ready;
        upstream_resp_o  = pass_resp;
      end
      ST_REPLAY: begin
        upstream_ready_o = 1'b0;
        upstream_resp_o  = RESP_OKAY;
      end
      ST_ERR1: begin
        upstream_ready_o = 1'b0;
        upstream_resp_o  = RESP_ERROR;
      end
      ST_ERR2: begin
        upstream_ready_o = 1'b1;
        upstream_resp_o  = RESP_ERROR;
      end
      ST_BLOCK: begin
        upstream_ready_o = 1'b1;
        upstream_resp_o  = RESP_OKAY;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      state_r    <= ST_PASS;
      blocking_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      blocking_r <= blocking_nxt;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      pend_r        <= CTRL_RESET;
      pend_master_r <= '0;
    end else if (replay) begin
      pend_r        <= upstream_ctrl_i;
      pend_master_r <= upstream_master_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      data_own_r <= 1'b0;
      data_sel_r <= 1'b0;
    end else if (downstream_ready_mux_o) begin
      data_own_r <= downstream_select_o && downstream_ctrl_o.trans[1];
      data_sel_r <= downstream_ctrl_o.addr[LANE_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  a_unsel_pass: assert property (
    (!upstream_select_i && !replaying) |->
      !downstream_select_o && downstream_ctrl_o.size == upstream_ctrl_i.size)
    else $error("unselected bridge drives select or alters size");
  a_unsel_ready: assert property (
    (!upstream_select_i && !replaying) |->
      downstream_ready_mux_o == upstream_ready_in_i)
    else $error("ready mux does not follow upstream ready");
  a_ctrl_pass: assert property (
    (acc && !is_wide && !err_end && !blocking_r) |->
      downstream_ctrl_o == upstream_ctrl_i)
    else $error("narrow control altered on downstream bus");
  a_write_lane: assert property (
    (downstream_ready_mux_o && downstream_select_o
     && downstream_ctrl_o.trans[1] && downstream_ctrl_o.write) |=>
      downstream_write_data_o == ($past(downstream_ctrl_o.addr[LANE_BIT])
        ? upstream_write_data_i[WIDE_W-1:NARROW_W]
        : upstream_write_data_i[NARROW_W-1:0]))
    else $error("wrong write data word routed");
  a_read_copy: assert property (
    (data_own_r && upstream_ready_o) |->
      upstream_read_data_o[WIDE_W-1:NARROW_W] == downstream_read_data_i
      && upstream_read_data_o[NARROW_W-1:0] == downstream_read_data_i)
    else $error("read data not replicated");
  a_err_fwd: assert property (
    (state_r == ST_PASS && data_own_r && downstream_slave_response_i) |->
      upstream_resp_o && upstream_ready_o == downstream_slave_ready_i)
    else $error("slave error not forwarded");
  a_replay_issue: assert property (
    replay |-> downstream_ctrl_o.trans == TRANS_IDLE ##1
      downstream_ready_mux_o && downstream_select_o
      && downstream_ctrl_o.trans == $past(upstream_ctrl_i.trans)
      && downstream_ctrl_o.addr == $past(upstream_ctrl_i.addr))
    else $error("captured request not replayed one cycle later");
  a_replay_wait: assert property (
    replay |=> !upstream_ready_o ##1
      upstream_ready_o == downstream_slave_ready_i)
    else $error("replay wait state missing or too long");
  a_block_err: assert property (
    (BLOCK_ALL_SIZES && err_end && acc && is_seq) |->
      downstream_ctrl_o.trans == TRANS_IDLE ##1
      (!upstream_ready_o && upstream_resp_o) ##1
      (upstream_ready_o && upstream_resp_o))
    else $error("blocked beat not answered with error");
  a_narrow_free: assert property (
    (!BLOCK_ALL_SIZES && err_end && acc && is_seq && !is_wide) |=>
      downstream_ctrl_o.trans == TRANS_SEQ && !upstream_ready_o)
    else $error("narrow beat blocked with block-all clear");
  a_block_idle: assert property (
    (state_r == ST_ERR1) |-> downstream_ctrl_o.trans == TRANS_IDLE
      && !upstream_ready_o && upstream_resp_o)
    else $error("blocked beat reached downstream bus");
  a_block_end: assert property (
    (blocking_r && (!upstream_select_i || (acc && is_nseq))) |=>
      !blocking_r)
    else $error("blocking did not end");
  a_busy_okay: assert property (
    (blocking_r && acc && is_busy) |=>
      upstream_ready_o && !upstream_resp_o && blocking_r)
    else $error("busy during blocking not okay");
  a_idle_okay: assert property (
    (state_r == ST_PASS && !data_own_r) |->
      upstream_ready_o && !upstream_resp_o)
    else $error("idle bridge stalls or errors");

  c_replay:  cover property (replay ##1 replaying ##1 upstream_ready_o);
  c_block:   cover property (blocking_r && local_err);
  c_busy:    cover property (blocking_r && local_busy);
  c_unblock: cover property (blocking_r ##1 !blocking_r);

endmodule

`default_nettype wire

// File: common/dsz_pkg.sv
// Shared constants and types for the 64-to-32 bit AHB-Lite width bridge.
`default_nettype none
package dsz_pkg;

  // ---------------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------------
  localparam int ADDR_W   = 32;
  localparam int WIDE_W   = 64;
  localparam int NARROW_W = 32;
  localparam int LANE_BIT = 2;

  // ---------------------------------------------------------------------
  // Transfer encodings
  // ---------------------------------------------------------------------
  localparam logic [1:0] TRANS_IDLE   = 2'h0;
  localparam logic [1:0] TRANS_BUSY   = 2'h1;
  localparam logic [1:0] TRANS_NONSEQ = 2'h2;
  localparam logic [1:0] TRANS_SEQ    = 2'h3;
  localparam logic [2:0] SIZE_64      = 3'h3;
  localparam logic       RESP_OKAY    = 1'h0;
  localparam logic       RESP_ERROR   = 1'h1;

  // ---------------------------------------------------------------------
  // Address phase control bundle
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [1:0]        trans;
    logic              write;
    logic [2:0]        size;
    logic [2:0]        burst;
    logic [3:0]        prot;
    logic              mastlock;
  } dsz_ctrl_t;

  localparam dsz_ctrl_t CTRL_RESET = '{
    addr: 32'h0000_0000, trans: 2'h0, write: 1'h0, size: 3'h0,
    burst: 3'h0, prot: 4'h0, mastlock: 1'h0};

  // Local response sequencer states.
  typedef enum logic [2:0] {
    ST_PASS,
    ST_REPLAY,
    ST_ERR1,
    ST_ERR2,
    ST_BLOCK
  } dsz_state_t;

endpackage
`default_nettype wire

// File: verification/dsz_slave_model.sv
// Behavioural 32-bit AHB-Lite slave on the narrow side of the bridge.
`timescale 1ns/1ps
`default_nettype none
module dsz_slave_model
  import dsz_pkg::*;
(
  input  wire logic                clock_i,
  input  wire logic                rstn_i,
  input  wire logic                select_i,
  input  wire dsz_pkg::dsz_ctrl_t  ctrl_i,
  input  wire logic                ready_mux_i,
  output var  logic                ready_o,
  output var  logic                resp_o,
  output var  logic [31:0]         read_data_o
);
  logic        dp_r;
  logic        wr_r;
  logic [31:0] addr_r;
  logic [31:0] last_r;
  logic [1:0]  cnt_r;
  // Address bit 31 answers ERROR in two cycles; bit 4 adds one wait.
  wire logic   err  = dp_r & addr_r[31];
  wire logic   slow = dp_r & (addr_r[4] | addr_r[31]);
  wire logic   rd_ok = dp_r & ready_o & ~wr_r & ~err;
  assign ready_o = ~slow | (cnt_r != 2'h0);
  assign resp_o  = err;
  // Data not being returned shows the inverse of the last value.
  assign read_data_o = rd_ok ? {addr_r[15:0], ~addr_r[31:16]} : ~last_r;
  always_ff @(posedge clock_i) begin
    last_r <= rstn_i ? read_data_o : 32'h0;
    if (!rstn_i) begin
      dp_r  <= 1'h0;
      cnt_r <= 2'h0;
    end else if (ready_mux_i) begin
      dp_r   <= select_i & ctrl_i.trans[1];
      addr_r <= ctrl_i.addr;
      wr_r   <= ctrl_i.write;
      cnt_r  <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_dsz_bridge.sv
// Self-checking bench for the 64-to-32 bit AHB-Lite bridge.
`timescale 1ns/1ps
`default_nettype none
module tb_dsz_bridge;
  import dsz_pkg::*;
  typedef struct packed {
    dsz_ctrl_t   c;
    logic [63:0] wd;
    logic        rsp;
    logic [1:0]  wt;
    logic [1:0]  kd;
  } dsz_beat_t;
  logic        clock_i, rstn_i, sel, oth, um, dn_m;
  logic        up_rdy, up_rsp, dn_sel, dn_rmx, s_rdy, s_rsp;
  dsz_ctrl_t   uc, dn_c;
  logic [63:0] uwd, up_rd;
  logic [31:0] dn_wd, s_rd, rng, t;
  dsz_beat_t   sq [6];
  int          err_total, samples_checked, i, j;
  wire logic   rdy_in = up_rdy & oth;
  logic        nb, nb_rdy, nb_rsp, nb_sel, nb_rmx, ns_rdy, ns_rsp;
  dsz_ctrl_t   nb_c;
  logic [31:0] ns_rd;
  wire logic   rdy_nb = nb_rdy & oth;

  dsz_bridge dut (.clock_i(clock_i), .rstn_i(rstn_i),
    .upstream_select_i(sel & ~nb), .upstream_ctrl_i(uc), .upstream_master_i(um),
    .upstream_write_data_i(uwd), .upstream_ready_in_i(rdy_in),
    .upstream_ready_o(up_rdy), .upstream_resp_o(up_rsp),
    .upstream_read_data_o(up_rd), .downstream_select_o(dn_sel),
    .downstream_ctrl_o(dn_c), .downstream_master_o(dn_m),
    .downstream_write_data_o(dn_wd), .downstream_ready_mux_o(dn_rmx),
    .downstream_read_data_i(s_rd), .downstream_slave_ready_i(s_rdy),
    .downstream_slave_response_i(s_rsp));
  dsz_slave_model slv (.clock_i(clock_i), .rstn_i(rstn_i), .select_i(dn_sel),
    .ctrl_i(dn_c), .ready_mux_i(dn_rmx), .ready_o(s_rdy), .resp_o(s_rsp),
    .read_data_o(s_rd));
  // Second bridge with block-all clear; selected only in its own test.
  dsz_bridge #(.BLOCK_ALL_SIZES(1'b0)) dut_nb (.clock_i(clock_i),
    .rstn_i(rstn_i), .upstream_select_i(sel & nb), .upstream_ctrl_i(uc),
    .upstream_master_i(um), .upstream_write_data_i(uwd),
    .upstream_ready_in_i(rdy_nb), .upstream_ready_o(nb_rdy),
    .upstream_resp_o(nb_rsp), .upstream_read_data_o(),
    .downstream_select_o(nb_sel), .downstream_ctrl_o(nb_c),
    .downstream_master_o(), .downstream_write_data_o(),
    .downstream_ready_mux_o(nb_rmx), .downstream_read_data_i(ns_rd),
    .downstream_slave_ready_i(ns_rdy), .downstream_slave_response_i(ns_rsp));
  dsz_slave_model slv_nb (.clock_i(clock_i), .rstn_i(rstn_i),
    .select_i(nb_sel), .ctrl_i(nb_c), .ready_mux_i(nb_rmx),
    .ready_o(ns_rdy), .resp_o(ns_rsp), .read_data_o(ns_rd));

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [31:0] exp_rd(input logic [31:0] a);
    return {a[15:0], ~a[31:16]};
  endfunction
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic put(input int k, input logic [31:0] a, input logic [1:0] tr,
    input logic w, input logic [2:0] s, input logic r,
    input logic [1:0] wt, input logic [1:0] kd);
    sq[k].c = '{addr: a, trans: tr, write: w, size: s, burst: 3'h1,
                prot: 4'h3, mastlock: 1'h0};
    sq[k].wd = {xs(), xs()};
    sq[k].rsp = r;
    sq[k].wt = wt;
    sq[k].kd = kd;
  endtask
  // Pipelined master: an address phase holds until ready is seen high.
  task automatic run(input int n);
    int a, d, w, g;
    a = 0;
    d = -1;
    w = 0;
    for (g = 0; g < 100 && (a < n || d >= 0); g++) begin
      @(negedge clock_i);
      sel = (a < n);
      oth = 1'b1;
      um = rng[3];
      uc = (a < n) ? sq[a].c : CTRL_RESET;
      uwd = (d >= 0) ? sq[d].wd : ~uwd;
      #1;
      w++;
      if (up_rdy === 1'b1) begin
        if (d >= 0) begin
          chk(up_rsp === sq[d].rsp, "response");
          if (sq[d].wt != 2'h0) chk(w == sq[d].wt, "wait count");
          if (sq[d].rsp == RESP_OKAY && sq[d].c.trans[1] && sq[d].c.write)
            chk(dn_wd === (sq[d].c.addr[2] ? sq[d].wd[63:32]
                           : sq[d].wd[31:0]), "write lane");
          if (sq[d].rsp == RESP_OKAY && sq[d].c.trans[1] && !sq[d].c.write)
            chk(up_rd === {2{exp_rd(sq[d].c.addr)}}, "read data");
        end
        if (a < n && sq[a].kd == 2'h1)
          chk(dn_sel === 1'b1 && dn_c === sq[a].c && dn_m === um,
              "pass ctrl");
        if (a < n && sq[a].kd == 2'h2)
          chk(dn_c.trans === TRANS_IDLE, "blocked beat");
        d = (a < n) ? a : -1;
        a++;
        w = 0;
      end
    end
    if (g >= 100) chk(1'b0, "transfer hung");
  endtask

  // ---------------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    rng = 32'hE64B;
    err_total = 0;
    samples_checked = 0;
    rstn_i = 1'b0;
    sel = 1'b0;
    oth = 1'b1;
    um = 1'b0;
    nb = 1'b0;
    uc = CTRL_RESET;
    uwd = 64'h0;
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    rstn_i = 1'b1;
    for (i = 0; i < 8; i++) begin
      @(negedge clock_i);
      oth = xs() > 32'h4000_0000;
      t = xs();
      uc = '{addr: t, trans: TRANS_NONSEQ, write: t[5], size: 3'(i % 3),
             burst: 3'h0, prot: 4'h0, mastlock: 1'h0};
      #1;
      chk(dn_sel === 1'b0 && dn_c.size === uc.size, "deselect");
      chk(dn_rmx === oth, "ready mux");
      chk(up_rdy === 1'b1 && up_rsp === RESP_OKAY, "idle answer");
    end
    $display("test deselect done");
    for (j = 0; j < 6; j++) begin
      for (i = 0; i < 4; i++) begin
        t = xs();
        put(i, t & 32'h7FFF_FFFC, TRANS_NONSEQ, t[7], 3'(t % 3), RESP_OKAY,
            t[4] ? 2'h2 : 2'h1, 2'h1);
      end
      run(4);
    end
    $display("test narrow done");
    put(0, 32'h8000_0010, TRANS_NONSEQ, 1'b0, 3'h2, RESP_ERROR, 2'h2, 2'h0);
    put(1, 32'h0000_0104, TRANS_NONSEQ, 1'b0, 3'h2, RESP_OKAY, 2'h2, 2'h0);
    put(2, 32'h0000_0A04, TRANS_NONSEQ, 1'b1, 3'h1, RESP_OKAY, 2'h1, 2'h1);
    run(3);
    $display("test replay done");
    put(0, 32'h8000_0000, TRANS_NONSEQ, 1'b0, 3'h2, RESP_ERROR, 2'h2, 2'h0);
    put(1, 32'h8000_0004, TRANS_SEQ, 1'b0, 3'h2, RESP_ERROR, 2'h2, 2'h2);
    put(2, 32'h8000_0008, TRANS_BUSY, 1'b0, 3'h2, RESP_OKAY, 2'h1, 2'h0);
    put(3, 32'h8000_0008, TRANS_SEQ, 1'b0, 3'h2, RESP_ERROR, 2'h2, 2'h2);
    put(4, 32'h0000_0020, TRANS_NONSEQ, 1'b0, 3'h2, RESP_OKAY, 2'h0, 2'h0);
    put(5, 32'h0000_0024, TRANS_SEQ, 1'b0, 3'h2, RESP_OKAY, 2'h1, 2'h1);
    run(6);
    $display("test blocking done");
    put(0, 32'h0000_0040, TRANS_NONSEQ, 1'b0, 3'h3, RESP_ERROR, 2'h2, 2'h2);
    run(1);
    @(negedge clock_i);
    #1;
    chk(up_rdy === 1'b1 && up_rsp === RESP_OKAY, "idle after error");
    $display("test wide refusal done");
    nb = 1'b1;
    @(negedge clock_i);
    sel = 1'b1;
    uc = '{addr: 32'h8000_0000, trans: TRANS_NONSEQ, write: 1'b0,
           size: 3'h2, burst: 3'h1, prot: 4'h3, mastlock: 1'h0};
    @(negedge clock_i);
    uc.addr = 32'h8000_0004;
    uc.trans = TRANS_SEQ;
    #1;
    chk(nb_rdy === 1'b0 && nb_rsp === RESP_ERROR, "slave error");
    @(negedge clock_i);
    #1;
    chk(nb_rdy === 1'b1 && nb_c.trans === TRANS_IDLE, "error end");
    @(negedge clock_i);
    sel = 1'b0;
    uc = CTRL_RESET;
    #1;
    chk(nb_rdy === 1'b0 && nb_sel === 1'b1 && nb_c.trans === TRANS_SEQ
        && nb_c.addr === 32'h8000_0004, "narrow beat held");
    repeat (3) @(negedge clock_i);
    #1;
    chk(nb_rdy === 1'b1 && nb_rsp === RESP_OKAY, "idle after replay");
    $display("test block-all clear done");
    stop_test();
  end
endmodule
`default_nettype wire
